// file: rtl/rdc_map.svh
// Contract
// - Halve the 5 MHz reference by toggling
// - Heterodyne output passes only while gated
// - Halved clock feeds divide-by-100 chain
// - Two toggle stages divide by four
// - Three-bit counters reset after fifth count
// - Cascade two div-5 stages to 25 kHz
// - 2 us strobe per 25 kHz period
// - Two more div-5 stages give 1 kHz
// - 5 kHz stage clocks the 1 kHz stage
// - Active-low 3-4 us strobe per 1 kHz
// - Inverted copy of the 1 kHz strobe
`ifndef RDC_MAP_SVH
`define RDC_MAP_SVH
// ==========================================
// Clock and timing
`define RDC_CLK_MHZ 250
`define RDC_STB25_NS 2000
`define RDC_STB1K_NS 3500
// ==========================================
// Divider layout
`define RDC_DIV4_LAST 2'h3
`define RDC_DIV5_LAST 3'h4
`define RDC_DIV5_ZERO 3'h0
`define RDC_DIV5_MSB 2
`define RDC_STAGES 4
`define RDC_STG_125K 0
`define RDC_STG_25K 1
`define RDC_STG_5K 2
`define RDC_STG_1K 3
`endif

// file: rtl/rdc_pkg.sv
package rdc_pkg;
  typedef logic [2:0] rdc_div5_t;
  typedef logic [1:0] rdc_div4_t;
endpackage

// file: rtl/rdc_top.sv
`timescale 1ns/1ps
`include "rdc_map.svh"
module rdc_top #(
  parameter int CNT_W = 10,
  parameter int STB25_CYC = (`RDC_STB25_NS * `RDC_CLK_MHZ + 999) / 1000,
  parameter int STB1K_CYC = (`RDC_STB1K_NS * `RDC_CLK_MHZ + 999) / 1000
) (
  // Clock, reset, enable
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  // Pins
  input wire logic ref_in,
  input wire logic het_gate_in,
  // Reference outputs
  output logic half_out,
  output logic het_out,
  output logic ref25k_out,
  output logic ref1k_out,
  // Loop strobes
  output logic stb25_out,
  output logic stb1k_n_out,
  output logic stb1k_out
);
  // ==========================================
  // Parameter checks
  // A strobe count must fit the stretch counter and last at least one cycle
  if (STB25_CYC < 1 || STB25_CYC >= (1 << CNT_W)) begin : g_bad_stb25
    $error("STB25_CYC out of range");
  end
  if (STB1K_CYC < 1 || STB1K_CYC >= (1 << CNT_W)) begin : g_bad_stb1k
    $error("STB1K_CYC out of range");
  end

  localparam logic [CNT_W-1:0] STB25_LOAD = CNT_W'(STB25_CYC);
  localparam logic [CNT_W-1:0] STB1K_LOAD = CNT_W'(STB1K_CYC);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  function automatic logic div5_last(input rdc_pkg::rdc_div5_t v);
    div5_last = (v == `RDC_DIV5_LAST);
  endfunction

  // ==========================================
  // Input synchronisers
  // Reference is sampled, so the 250 MHz clock must stay well above 10 MHz
  logic ref_s1_r, ref_s2_r, ref_s3_r;
  logic gate_s1_r, gate_s2_r;
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ref_s1_r <= 1'b0;
      ref_s2_r <= 1'b0;
      ref_s3_r <= 1'b0;
      gate_s1_r <= 1'b0;
      gate_s2_r <= 1'b0;
    end else if (ce_in) begin
      ref_s1_r <= ref_in;
      ref_s2_r <= ref_s1_r;
      ref_s3_r <= ref_s2_r;
      gate_s1_r <= het_gate_in;
      gate_s2_r <= gate_s1_r;
    end
  end
  wire ref_tick = ce_in & ref_s2_r & ~ref_s3_r;

  // ==========================================
  // Toggle halver and divide by four
  logic half_r;
  rdc_pkg::rdc_div4_t div4_r;
  wire half_nxt = half_r ^ ref_tick;
  wire half_tick = ref_tick & ~half_r;
  wire tick625 = half_tick & (div4_r == `RDC_DIV4_LAST);
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      half_r <= 1'b0;
      div4_r <= '0;
    end else if (ce_in) begin
      half_r <= half_nxt;
      if (half_tick) begin
        div4_r <= div4_r + 2'h1;
      end
    end
  end

  // ==========================================
  // Divide-by-five chain
  rdc_pkg::rdc_div5_t cnt_r [`RDC_STAGES];
  logic [`RDC_STAGES-1:0] stg_en;
  logic [`RDC_STAGES-1:0] stg_wrap;
  assign stg_en[0] = tick625;
  // Declared ahead of the loop that asserts them per stage
  property p_div5_range(rdc_pkg::rdc_div5_t c);
    @(posedge clock_in) disable iff (!arst_n_in) c <= `RDC_DIV5_LAST;
  endproperty
  property p_div5_wrap(logic w, rdc_pkg::rdc_div5_t c);
    @(posedge clock_in) disable iff (!arst_n_in) w |=> c == `RDC_DIV5_ZERO;
  endproperty
  genvar gi;
  generate
    for (gi = 0; gi < `RDC_STAGES; gi++) begin : g_div5
      assign stg_wrap[gi] = stg_en[gi] & div5_last(cnt_r[gi]);
      if (gi > 0) begin : g_link
        assign stg_en[gi] = stg_wrap[gi-1];
      end
      always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          cnt_r[gi] <= `RDC_DIV5_ZERO;
        end else if (ce_in && stg_en[gi]) begin
          cnt_r[gi] <= stg_wrap[gi] ? `RDC_DIV5_ZERO : cnt_r[gi] + 3'h1;
        end
      end
      a_div5_range: assert property (p_div5_range(cnt_r[gi])) else $error("div5 counter left 0..4");
      a_div5_wrap: assert property (p_div5_wrap(stg_wrap[gi], cnt_r[gi])) else $error("div5 did not reset");
    end
  endgenerate

  // ==========================================
  // Strobe stretchers
  // Width counts clock_in cycles with ce_in high, so a low ce_in stretches the strobes too
  logic [CNT_W-1:0] stb25_cnt_r, stb1k_cnt_r;
  wire load25 = stg_wrap[`RDC_STG_25K];
  wire load1k = stg_wrap[`RDC_STG_1K];
  wire [CNT_W-1:0] stb25_nxt = load25 ? STB25_LOAD :
    (stb25_cnt_r != CNT_ZERO) ? stb25_cnt_r - CNT_ONE : CNT_ZERO;
  wire [CNT_W-1:0] stb1k_nxt = load1k ? STB1K_LOAD :
    (stb1k_cnt_r != CNT_ZERO) ? stb1k_cnt_r - CNT_ONE : CNT_ZERO;
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stb25_cnt_r <= CNT_ZERO;
      stb1k_cnt_r <= CNT_ZERO;
    end else if (ce_in) begin
      stb25_cnt_r <= stb25_nxt;
      stb1k_cnt_r <= stb1k_nxt;
    end
  end

  // ==========================================
  // Registered outputs
  wire het_nxt = half_nxt & gate_s2_r;
  wire stb1k_act = (stb1k_nxt != CNT_ZERO);
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      half_out <= 1'b0;
      het_out <= 1'b0;
      ref25k_out <= 1'b0;
      ref1k_out <= 1'b0;
      stb25_out <= 1'b0;
      stb1k_n_out <= 1'b1;
      stb1k_out <= 1'b0;
    end else if (ce_in) begin
      half_out <= half_nxt;
      het_out <= het_nxt;
      ref25k_out <= cnt_r[`RDC_STG_25K][`RDC_DIV5_MSB];
      ref1k_out <= cnt_r[`RDC_STG_1K][`RDC_DIV5_MSB];
      stb25_out <= (stb25_nxt != CNT_ZERO);
      stb1k_n_out <= ~stb1k_act;
      stb1k_out <= stb1k_act;
    end
  end

  // ==========================================
  // Assertions

  sequence s_ref_tick;
    ref_tick;
  endsequence
  property p_half_toggle;
    @(posedge clock_in) disable iff (!arst_n_in) s_ref_tick |=> half_out != $past(half_out);
  endproperty
  a_half_toggle: assert property (p_half_toggle) else $error("half did not toggle");

  property p_half_hold;
    @(posedge clock_in) disable iff (!arst_n_in) (ce_in && !ref_tick) |=> $stable(half_out);
  endproperty
  a_half_hold: assert property (p_half_hold) else $error("half moved without a reference edge");

  property p_ce_freeze;
    @(posedge clock_in) disable iff (!arst_n_in)
      !ce_in |=> $stable(half_out) && $stable(div4_r) && $stable(stb25_cnt_r) && $stable(stb1k_cnt_r);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while disabled");

  property p_het_block;
    @(posedge clock_in) disable iff (!arst_n_in) (ce_in && !gate_s2_r) |=> !het_out;
  endproperty
  a_het_block: assert property (p_het_block) else $error("heterodyne not blocked");

  property p_het_pass;
    @(posedge clock_in) disable iff (!arst_n_in) (ce_in && gate_s2_r) |=> het_out == half_out;
  endproperty
  a_het_pass: assert property (p_het_pass) else $error("heterodyne not passed");

  property p_div4;
    @(posedge clock_in) disable iff (!arst_n_in) half_tick |=> div4_r == $past(div4_r) + 2'h1;
  endproperty
  a_div4: assert property (p_div4) else $error("625 kHz tick misplaced");

  sequence s_load25;
    ce_in && load25;
  endsequence
  property p_stb25_rise;
    @(posedge clock_in) disable iff (!arst_n_in) s_load25 |=> stb25_out && stb25_cnt_r == STB25_LOAD;
  endproperty
  a_stb25_rise: assert property (p_stb25_rise) else $error("25 kHz strobe not started");

  property p_stb25_end;
    @(posedge clock_in) disable iff (!arst_n_in) $fell(stb25_out) |-> $past(stb25_cnt_r) == CNT_ONE;
  endproperty
  a_stb25_end: assert property (p_stb25_end) else $error("25 kHz strobe wrong width");

  property p_stb1k_end;
    @(posedge clock_in) disable iff (!arst_n_in) $rose(stb1k_n_out) |-> $past(stb1k_cnt_r) == CNT_ONE;
  endproperty
  a_stb1k_end: assert property (p_stb1k_end) else $error("1 kHz strobe wrong width");

  property p_stb1k_start;
    @(posedge clock_in) disable iff (!arst_n_in) (ce_in && load1k) |=> !stb1k_n_out ##1 !stb1k_n_out;
  endproperty
  a_stb1k_start: assert property (p_stb1k_start) else $error("1 kHz strobe not started");

  property p_stb1k_pair;
    @(posedge clock_in) disable iff (!arst_n_in) stb1k_out == !stb1k_n_out;
  endproperty
  a_stb1k_pair: assert property (p_stb1k_pair) else $error("1 kHz strobes not complementary");

  property p_1k_chain;
    @(posedge clock_in) disable iff (!arst_n_in) load1k |-> div4_r == `RDC_DIV4_LAST &&
      cnt_r[`RDC_STG_125K] == `RDC_DIV5_LAST && cnt_r[`RDC_STG_25K] == `RDC_DIV5_LAST &&
      cnt_r[`RDC_STG_5K] == `RDC_DIV5_LAST;
  endproperty
  a_1k_chain: assert property (p_1k_chain) else $error("1 kHz chain out of order");
endmodule

// file: testbench/rdc_ref_osc.sv
`timescale 1ns/1ps
// ==========================================
// Reference oscillator, free running
module rdc_ref_osc #(
  // Sped up from 5 MHz so a full 1 kHz period fits the run
  parameter int HALF_NS = 16
) (
  // Reference
  output logic ref_out
);
  // Offset by 1 ns so pin edges never meet a clock edge
  initial begin
    ref_out = 1'b0;
    #1;
    forever #(HALF_NS) ref_out = ~ref_out;
  end
endmodule

// file: testbench/reference_divider_chain_tb_top.sv
`timescale 1ns/1ps
module reference_divider_chain_tb_top;
  localparam int P25 = 20;
  localparam int P1K = 30;
  logic clock_in = 1'b0, arst_n_in = 1'b0, ce_in = 1'b1, het_gate_in = 1'b0, ref_in;
  logic half_out, het_out, ref25k_out, ref1k_out, stb25_out, stb1k_n_out, stb1k_out;
  logic p_half, p25, p1k, p_s25, p_s1n, h0, mon = 1'b0;
  int failures = 0, n_tests = 0, hc25, hc1k, w25, w1k, ns25, ns1k, nref, r25;
  bit seen25, seen1k;
  // Rows are {gate, enable, heterodyne follows half}
  logic [2:0] rows [4] = '{3'b111, 3'b010, 3'b111, 3'b101};
  always #2 clock_in = ~clock_in;
  rdc_ref_osc ref_u (.ref_out(ref_in));
  always @(posedge ref_in) nref++;
  rdc_top #(.STB25_CYC(P25), .STB1K_CYC(P1K)) dut_u (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .ce_in(ce_in), .ref_in(ref_in), .het_gate_in(het_gate_in), .half_out(half_out), .het_out(het_out),
    .ref25k_out(ref25k_out), .ref1k_out(ref1k_out), .stb25_out(stb25_out), .stb1k_n_out(stb1k_n_out),
    .stb1k_out(stb1k_out));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========================================
  // Period and width monitor
  // Sampled mid-cycle, away from the edge that launches the outputs
  always @(negedge clock_in) begin
    if (mon) begin
      chk(16'(stb1k_out), 16'(!stb1k_n_out));
      if (half_out && !p_half) begin
        hc25++;
        hc1k++;
      end
      if (stb25_out) w25++;
      else if (p_s25 && seen25) chk(16'(w25), 16'(P25));
      if (!stb25_out) w25 = 0;
      if (stb25_out && !p_s25) ns25++;
      if (!stb1k_n_out) w1k++;
      else if (!p_s1n && seen1k) chk(16'(w1k), 16'(P1K));
      if (stb1k_n_out) w1k = 0;
      if (!stb1k_n_out && p_s1n) ns1k++;
      if (ref25k_out && !p25) begin
        if (seen25) chk(16'(hc25), 16'd100);
        if (seen25) chk(16'(nref - r25), 16'd200);
        r25 = nref;
        if (seen25) chk(16'(ns25), 16'd1);
        seen25 = 1;
        hc25 = 0;
        ns25 = 0;
      end
      if (ref1k_out && !p1k) begin
        if (seen1k) chk(16'(hc1k), 16'd2500);
        if (seen1k) chk(16'(ns1k), 16'd1);
        seen1k = 1;
        hc1k = 0;
        ns1k = 0;
      end
    end
    {p_half, p25, p1k, p_s25, p_s1n} = {half_out, ref25k_out, ref1k_out, stb25_out, stb1k_n_out};
  end
  // ==========================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clock_in);
    #1 chk({half_out, het_out, ref25k_out, ref1k_out, stb25_out, stb1k_n_out, stb1k_out}, 16'h0002);
    arst_n_in = 1'b1;
    // Nothing may move on the first edge after release
    @(posedge clock_in);
    #1 chk({half_out, het_out, ref25k_out, ref1k_out, stb25_out, stb1k_n_out, stb1k_out}, 16'h0002);
    // A frozen row keeps the gate so the synchroniser matches
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_in);
      #1 {het_gate_in, ce_in} = rows[i][2:1];
      repeat (6) @(posedge clock_in);
      #1 h0 = half_out;
      repeat (40) begin
        @(posedge clock_in);
        #1 chk(16'(het_out), 16'(rows[i][0] & half_out));
        if (!ce_in) chk(16'(half_out), 16'(h0));
      end
    end
    @(posedge clock_in);
    #1 ce_in = 1'b1;
    mon = 1'b1;
    repeat (84000) @(posedge clock_in);
    #1 mon = 1'b0;
    // Reset in mid-run must return every output to reset at once, stb1k_n_out high and the rest low
    arst_n_in = 1'b0;
    #1 chk({half_out, het_out, ref25k_out, ref1k_out, stb25_out, stb1k_n_out, stb1k_out}, 16'h0002);
    tally_and_finish();
  end
  initial begin
    #400000;
    failures++;
    tally_and_finish();
  end
endmodule
